// >>> core/ief_irq_ctrl.sv
// Interrupt enable and flag logic with an Avalon-MM register slave.
// Assumes event strobes come from logic on clk_i; the external pin is async.
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

// Functional notes
// - Global enable bit 7 gates every interrupt to the core.
// - Peripheral gate bit 6 passes or blocks all peripheral sources.
// - Control bits 5,4,3 enable timer, external pin and pin-change sources.
// - Timer overflow sets control bit 2; it stays until software writes 0.
// - A qualifying external pin edge sets control bit 1.
// - Control bit 0 is high while any per-pin change flag is set.
// - Control bit 0 is read-only and clears only with all per-pin flags.
// - Flags set on their events regardless of any enable bit.
// - Peripheral enables: converter 6, oscillator 4, logic cell 3, match 1.
// - Converter done sets request bit 6; reads 0 when nothing pending.
// - Oscillator overflow sets request bit 4; only software clears it.
// - Logic cell output rising edge sets request bit 3 until cleared.
// - Period match sets request bit 1 after postscaler setting plus one matches.
// - Peripheral bits 7,5,2,0 read zero and ignore writes.
// - Every implemented bit except control bit 0 resets to zero on any reset; bit 0 follows the per-pin flags.
// - Accepted interrupt clears global enable and presents vector 0004h.
// - External pin triggers on rising edge if select is 1, else falling.
// - Return from interrupt sets the global enable again.
module ief_irq_ctrl #(
  parameter int PIN_W = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM register slave
  input wire ief_pkg::ief_av_req_t av_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o,
  // Peripheral events
  input wire ief_pkg::ief_ev_t ev_i,
  input wire logic [PIN_W-1:0] per_pin_change_flags_i,
  input wire logic ext_pin_i,
  // Core side
  input wire logic irq_accept_i,
  input wire logic return_from_irq_instr_i,
  output logic irq_req_o,
  output logic [15:0] vector_addr_o
);
  import ief_pkg::*;

  // Bus handshake state
  logic req;
  logic done_q;
  logic accept;
  logic [31:0] rdata_q;

  // Control register state
  logic global_irq_enable_q;
  logic peripheral_irq_gate_q;
  logic timer_a_overflow_enable_q;
  logic ext_pin_irq_enable_q;
  logic pin_change_irq_enable_q;
  logic timer_a_overflow_flag_q;
  logic ext_pin_irq_flag_q;
  logic pin_change_summary_flag;

  // Peripheral enable, request and configuration state
  logic [7:0] pen_q;
  logic [7:0] preq_q;
  logic [7:0] cfg_q;
  logic [POST_W-1:0] post_cnt_q;
  logic logic_prev_q;
  logic [15:0] vector_q;

  // Event helpers
  logic ext_edge;
  logic logic_rise;
  logic post_hit;
  logic [7:0] preq_set;
  logic [7:0] ctrl_rd;
  logic core_pend;
  logic per_pend;
  logic wr_ctrl;
  logic wr_pen;
  logic wr_preq;
  logic wr_cfg;
  logic [7:0] wbyte;

  // Address match against one register offset
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction

  // Register readback value for one offset
  function automatic logic [7:0] rd_mux(input logic [3:0] addr, input logic [7:0] ctrl,
                                        input logic [7:0] pen, input logic [7:0] preq,
                                        input logic [7:0] cfg);
    rd_mux = 8'h00;
    if (hit(addr, OFS_CTRL)) begin
      rd_mux = ctrl;
    end else if (hit(addr, OFS_PEN)) begin
      rd_mux = pen & PER_MASK;
    end else if (hit(addr, OFS_PREQ)) begin
      rd_mux = preq & PER_MASK;
    end else if (hit(addr, OFS_CFG)) begin
      rd_mux = cfg;
    end
  endfunction

  // Wait one cycle on every access, then accept it
  assign req = av_i.read | av_i.write;
  assign av_waitrequest_o = req & ~done_q;
  assign accept = req & done_q;
  assign av_readdata_o = rdata_q;
  assign wbyte = av_i.writedata[7:0];

  // Write strobes, low byte lane only
  assign wr_ctrl = accept & av_i.write & av_i.byteenable[0] & hit(av_i.address, OFS_CTRL);
  assign wr_pen = accept & av_i.write & av_i.byteenable[0] & hit(av_i.address, OFS_PEN);
  assign wr_preq = accept & av_i.write & av_i.byteenable[0] & hit(av_i.address, OFS_PREQ);
  assign wr_cfg = accept & av_i.write & av_i.byteenable[0] & hit(av_i.address, OFS_CFG);

  // Handshake phase toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= req & ~done_q;
    end
  end

  // Read data captured in the wait cycle, held for the accepting edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (av_i.read & ~done_q) begin
      rdata_q <= {24'h00_0000, rd_mux(av_i.address, ctrl_rd, pen_q, preq_q, cfg_q)};
    end
  end

  // External pin synchroniser and edge qualifier
  ief_pin_sync u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_pin_i),
    .rising_i(cfg_q[CFG_EDGE]),
    .edge_o(ext_edge)
  );

  // Summary flag follows the per-pin flags, never stored
  assign pin_change_summary_flag = |per_pin_change_flags_i;

  // Readback image of the control register
  assign ctrl_rd = {global_irq_enable_q, peripheral_irq_gate_q, timer_a_overflow_enable_q,
                    ext_pin_irq_enable_q, pin_change_irq_enable_q, timer_a_overflow_flag_q,
                    ext_pin_irq_flag_q, pin_change_summary_flag};

  // Global enable: software write, cleared on accept, set by return
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable_q <= CTRL_RST[CTRL_GIE];
    end else if (return_from_irq_instr_i) begin
      global_irq_enable_q <= 1'b1;
    end else if (irq_accept_i & global_irq_enable_q) begin
      global_irq_enable_q <= 1'b0;
    end else if (wr_ctrl) begin
      global_irq_enable_q <= wbyte[CTRL_GIE];
    end
  end

  // Writable enables of the control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_irq_gate_q <= CTRL_RST[CTRL_PGATE];
      timer_a_overflow_enable_q <= CTRL_RST[CTRL_TA_EN];
      ext_pin_irq_enable_q <= CTRL_RST[CTRL_EXT_EN];
      pin_change_irq_enable_q <= CTRL_RST[CTRL_PC_EN];
    end else if (wr_ctrl) begin
      peripheral_irq_gate_q <= wbyte[CTRL_PGATE];
      timer_a_overflow_enable_q <= wbyte[CTRL_TA_EN];
      ext_pin_irq_enable_q <= wbyte[CTRL_EXT_EN];
      pin_change_irq_enable_q <= wbyte[CTRL_PC_EN];
    end
  end

  // Control register flags; a new event beats a clearing write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_a_overflow_flag_q <= CTRL_RST[CTRL_TA_FLAG];
      ext_pin_irq_flag_q <= CTRL_RST[CTRL_EXT_FLAG];
    end else begin
      timer_a_overflow_flag_q <= (wr_ctrl ? wbyte[CTRL_TA_FLAG] : timer_a_overflow_flag_q)
                                 | ev_i.timer_a_overflow;
      ext_pin_irq_flag_q <= (wr_ctrl ? wbyte[CTRL_EXT_FLAG] : ext_pin_irq_flag_q)
                            | ext_edge;
    end
  end

  // Peripheral enables, unimplemented bits never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pen_q <= PER_RST;
    end else if (wr_pen) begin
      pen_q <= wbyte & PER_MASK;
    end
  end

  // Configuration: edge select and postscaler setting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= wbyte;
    end
  end

  // Logic cell output history for rising-edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      logic_prev_q <= 1'b0;
    end else begin
      logic_prev_q <= ev_i.logic_cell_out;
    end
  end

  assign logic_rise = ev_i.logic_cell_out & ~logic_prev_q;

  // Postscaler: setting N flags on every N+1-th match
  assign post_hit = ev_i.period_match & (post_cnt_q == cfg_q[CFG_POST_LSB +: POST_W]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      post_cnt_q <= POST_RST;
    end else if (wr_cfg) begin
      post_cnt_q <= POST_RST;
    end else if (post_hit) begin
      post_cnt_q <= POST_RST;
    end else if (ev_i.period_match) begin
      post_cnt_q <= post_cnt_q + 4'h1;
    end
  end

  // Peripheral set terms
  always_comb begin
    preq_set = 8'h00;
    preq_set[PER_CONV] = ev_i.converter_done;
    preq_set[PER_OSC] = ev_i.num_osc_overflow;
    preq_set[PER_LOGIC] = logic_rise;
    preq_set[PER_MATCH] = post_hit;
  end

  // Peripheral request flags; hardware sets, only software clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preq_q <= PER_RST;
    end else begin
      preq_q <= ((wr_preq ? wbyte : preq_q) | preq_set) & PER_MASK;
    end
  end

  // Combined request to the core
  assign core_pend = (timer_a_overflow_flag_q & timer_a_overflow_enable_q)
                   | (ext_pin_irq_flag_q & ext_pin_irq_enable_q)
                   | (pin_change_summary_flag & pin_change_irq_enable_q);
  assign per_pend = peripheral_irq_gate_q & (|(preq_q & pen_q));
  assign irq_req_o = global_irq_enable_q & (core_pend | per_pend);

  // Vector address for the core
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_q <= IRQ_VECTOR;
    end else begin
      vector_q <= IRQ_VECTOR;
    end
  end

  assign vector_addr_o = vector_q;

  // Global enable low blocks everything
  property p_gie_blocks;
    @(posedge clk_i) disable iff (rst_i)
    !global_irq_enable_q |-> !irq_req_o;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks) else $error("request with global enable low");

  // Peripheral gate low blocks peripheral-only requests
  property p_gate_blocks;
    @(posedge clk_i) disable iff (rst_i)
    (!peripheral_irq_gate_q && !core_pend) |-> !irq_req_o;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("peripheral request passed closed gate");

  // Timer overflow sets its flag on the next edge, whatever the enables
  property p_timer_flag;
    @(posedge clk_i) disable iff (rst_i)
    ev_i.timer_a_overflow |=> timer_a_overflow_flag_q;
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("timer overflow flag not set");

  // A qualified pin edge sets the flag on the next edge
  property p_ext_flag;
    @(posedge clk_i) disable iff (rst_i)
    ext_edge |=> ext_pin_irq_flag_q;
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("external flag not set after edge");

  // Control readback bit 0 mirrors the per-pin flags at capture
  property p_summary_read;
    @(posedge clk_i) disable iff (rst_i)
    (av_i.read && !done_q && hit(av_i.address, OFS_CTRL))
      |=> av_readdata_o[CTRL_PC_FLAG] == $past(pin_change_summary_flag);
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary flag readback wrong");

  // Unimplemented peripheral bits read as zero
  property p_unimpl_zero;
    @(posedge clk_i) disable iff (rst_i)
    (accept && av_i.read && (hit(av_i.address, OFS_PEN) || hit(av_i.address, OFS_PREQ)))
      |-> (av_readdata_o[7:0] & ~PER_MASK) == 8'h00;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read as one");

  // Acceptance drops the global enable
  property p_accept_clear;
    @(posedge clk_i) disable iff (rst_i)
    (irq_accept_i && global_irq_enable_q && !return_from_irq_instr_i) |=> !global_irq_enable_q;
  endproperty
  a_accept_clear: assert property (p_accept_clear) else $error("global enable kept after accept");

  // Return restores the global enable
  property p_return_set;
    @(posedge clk_i) disable iff (rst_i)
    return_from_irq_instr_i |=> global_irq_enable_q;
  endproperty
  a_return_set: assert property (p_return_set) else $error("global enable not restored");

  // Match below the postscaler count leaves a clear flag clear
  property p_postscale;
    @(posedge clk_i) disable iff (rst_i)
    (ev_i.period_match && !post_hit && !wr_preq && !preq_q[PER_MATCH]) |=> !preq_q[PER_MATCH];
  endproperty
  a_postscale: assert property (p_postscale) else $error("match flag set before postscaler count");

  // Oscillator flag holds until software writes
  property p_osc_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (preq_q[PER_OSC] && !wr_preq) |=> preq_q[PER_OSC];
  endproperty
  a_osc_sticky: assert property (p_osc_sticky) else $error("oscillator flag lost");

  // Enabled timer flag with global enable raises the request
  property p_req_timer;
    @(posedge clk_i) disable iff (rst_i)
    (global_irq_enable_q && timer_a_overflow_flag_q && timer_a_overflow_enable_q) |-> irq_req_o;
  endproperty
  a_req_timer: assert property (p_req_timer) else $error("enabled timer flag gave no request");

endmodule

// >>> shared/ief_pkg.sv
// Package for the interrupt enable and flag logic: register map, bit fields,
// reset values and the packed carriers shared by the core and its top.
// Assumes byte addresses on a 32-bit Avalon-MM slave, one register per word.
package ief_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PEN = 4'h4;
  localparam logic [3:0] OFS_PREQ = 4'h8;
  localparam logic [3:0] OFS_CFG = 4'hC;

  // Interrupt control register fields
  localparam int CTRL_GIE = 7;
  localparam int CTRL_PGATE = 6;
  localparam int CTRL_TA_EN = 5;
  localparam int CTRL_EXT_EN = 4;
  localparam int CTRL_PC_EN = 3;
  localparam int CTRL_TA_FLAG = 2;
  localparam int CTRL_EXT_FLAG = 1;
  localparam int CTRL_PC_FLAG = 0;

  // Peripheral enable and request register fields
  localparam int PER_CONV = 6;
  localparam int PER_OSC = 4;
  localparam int PER_LOGIC = 3;
  localparam int PER_MATCH = 1;
  localparam logic [7:0] PER_MASK = 8'h5A;

  // Configuration register fields
  localparam int CFG_EDGE = 0;
  localparam int CFG_POST_LSB = 4;
  localparam int POST_W = 4;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PER_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [POST_W-1:0] POST_RST = 4'h0;

  // Interrupt vector handed to the core
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ief_av_req_t;

  // Event strobes and levels from the peripherals
  typedef struct packed {
    logic timer_a_overflow;
    logic converter_done;
    logic num_osc_overflow;
    logic logic_cell_out;
    logic period_match;
  } ief_ev_t;

endpackage

// >>> core/ief_pin_sync.sv
// Two-stage synchroniser for the external interrupt pin with edge select.
// Assumes the pin is asynchronous to clk_i; output is a one-cycle pulse.
`timescale 1ns/1ps
module ief_pin_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and edge choice
  input wire logic pin_i,
  input wire logic rising_i,
  // Qualified edge pulse
  output logic edge_o
);
  import ief_pkg::*;

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Synchroniser stages, first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // Previous synchronised level for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= sync_q;
    end
  end

  // Rising or falling edge as selected
  assign edge_o = rising_i ? (sync_q & ~prev_q) : (~sync_q & prev_q);

endmodule

// >>> verification/ief_far_model.sv
// Far-side model: peripheral event sources, pin-change flags, external pin and core.
// Assumes the bench calls its tasks just after a rising edge of clk_i.
`timescale 1ns/1ps
module ief_far_model (
  // Clock
  input wire logic clk_i,
  // Peripheral side
  output ief_pkg::ief_ev_t ev_o,
  output logic [3:0] pins_o,
  output logic ext_pin_o,
  // Core side
  output logic accept_o,
  output logic ret_o
);
  import ief_pkg::*;

  // Quiet outputs from time zero
  initial begin
    ev_o = '0;
    pins_o = 4'h0;
    ext_pin_o = 1'b0;
    accept_o = 1'b0;
    ret_o = 1'b0;
  end

  // Event on source s: 0 timer, 1 converter, 2 oscillator, 3 logic cell, 4 match
  task automatic fire(input int s);
    ief_ev_t ev;
    ev = '0;
    ev[4-s] = 1'b1;
    @(posedge clk_i);
    ev_o <= ev;
    @(posedge clk_i);
    // Logic cell output is a level that stays high a while; only its rise counts
    if (s == 3) repeat (2) @(posedge clk_i);
    ev_o <= '0;
  endtask

  // Per-pin change flags as levels
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask

  // External pin level, changed just after a clock edge; the design syncs it
  task automatic set_ext(input logic v);
    @(posedge clk_i);
    ext_pin_o <= v;
  endtask

  // Core accepts an interrupt (r = 0) or returns from one (r = 1)
  task automatic core(input logic r);
    @(posedge clk_i);
    accept_o <= ~r;
    ret_o <= r;
    @(posedge clk_i);
    accept_o <= 1'b0;
    ret_o <= 1'b0;
  endtask
endmodule

// >>> verification/ief_irq_ctrl_bench.sv
// Self-checking bench for the interrupt enable and flag logic.
// Assumes the far-side model drives events and core strobes; the bench is the bus master.
`timescale 1ns/1ps
module ief_irq_ctrl_bench;
  import ief_pkg::*;

  // Table row: address, write value, expected read, expected request
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic q;
  } ief_row_t;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ief_av_req_t av = '0;
  logic [31:0] rdata;
  logic wait_rq;
  ief_ev_t ev;
  logic [3:0] pins;
  logic ext_pin;
  logic accept;
  logic ret;
  logic irq;
  logic [15:0] vec;
  logic [31:0] rd;
  logic [3:0] be = 4'hF;
  logic [7:0] masks [4] = '{8'h40, 8'h10, 8'h08, 8'h02};
  ief_row_t rows [12];
  int num_errors = 0;
  int comparisons = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  ief_irq_ctrl #(.PIN_W(4)) u_ief_irq_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .av_i(av), .av_readdata_o(rdata), .av_waitrequest_o(wait_rq),
    .ev_i(ev), .per_pin_change_flags_i(pins), .ext_pin_i(ext_pin), .irq_accept_i(accept),
    .return_from_irq_instr_i(ret), .irq_req_o(irq), .vector_addr_o(vec)
  );

  ief_far_model u_ief_far_model (
    .clk_i(clk_i), .ev_o(ev), .pins_o(pins), .ext_pin_o(ext_pin), .accept_o(accept), .ret_o(ret)
  );

  // Verdict and end of run
  task automatic print_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare and report
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    av.read <= ~wr;
    av.write <= wr;
    av.address <= a;
    av.writedata <= {4{d}};
    av.byteenable <= be;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_rq !== 1'b0 && n < 16);
    if (wait_rq !== 1'b0) begin
      check("waitrequest", 32'h0, 32'(wait_rq));
      print_verdict();
    end
    // One wait cycle, accepted at the second edge
    check("wait_cycles", 32'd2, 32'(n));
    rd = rdata;
    av.read <= 1'b0;
    av.write <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check("readdata", 32'(exp), rd);
  endtask

  task automatic irq_is(input logic exp);
    @(posedge clk_i);
    check("irq_req_o", 32'(exp), 32'(irq));
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    check("run_length", 32'h0, 32'h1);
    print_verdict();
  end

  // Main sequence
  initial begin
    rows = '{
      '{OFS_CTRL, 8'hFE, 8'hFE, 1'b1}, '{OFS_CTRL, 8'h7F, 8'h7E, 1'b0},
      '{OFS_CTRL, 8'h00, 8'h00, 1'b0}, '{OFS_PEN, 8'hFF, 8'h5A, 1'b0},
      '{OFS_PREQ, 8'hFF, 8'h5A, 1'b0}, '{OFS_CTRL, 8'hC0, 8'hC0, 1'b1},
      '{OFS_CTRL, 8'h80, 8'h80, 1'b0}, '{OFS_PEN, 8'hA5, 8'h00, 1'b0},
      '{OFS_CTRL, 8'hC0, 8'hC0, 1'b0}, '{OFS_PEN, 8'h08, 8'h08, 1'b1},
      '{OFS_PREQ, 8'hA5, 8'h00, 1'b0}, '{4'h3, 8'hFF, 8'h00, 1'b0}};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("vector_addr_o", 32'h0000_0004, 32'(vec));
    for (int i = 0; i < 3; i++) begin
      rdchk(4'(4 * i), 8'h00);
    end
    // Writes without the low byte lane are ignored, lane 0 alone lands
    be = 4'hE;
    bus(1'b1, OFS_CTRL, 8'hFE);
    rdchk(OFS_CTRL, 8'h00);
    be = 4'h1;
    bus(1'b1, OFS_PEN, 8'h5A);
    rdchk(OFS_PEN, 8'h5A);
    be = 4'hF;
    // Ordinary register cases
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
      check("irq_req_o", 32'(rows[i].q), 32'(irq));
    end
    bus(1'b1, OFS_CTRL, 8'h00);
    // Timer flag, core accept and return
    u_ief_far_model.fire(0);
    rdchk(OFS_CTRL, 8'h04);
    bus(1'b1, OFS_CTRL, 8'h00);
    bus(1'b1, OFS_CTRL, 8'hA0);
    irq_is(1'b0);
    u_ief_far_model.fire(0);
    irq_is(1'b1);
    repeat (5) @(posedge clk_i);
    rdchk(OFS_CTRL, 8'hA4);
    u_ief_far_model.core(1'b0);
    irq_is(1'b0);
    rdchk(OFS_CTRL, 8'h24);
    u_ief_far_model.core(1'b1);
    irq_is(1'b1);
    bus(1'b1, OFS_CTRL, 8'h00);
    irq_is(1'b0);
    // Peripheral sources, postscaler 2 so a match flags on every third event
    bus(1'b1, OFS_CFG, 8'h20);
    for (int s = 1; s < 5; s++) begin
      bus(1'b1, OFS_PREQ, 8'h00);
      bus(1'b1, OFS_PEN, masks[s-1]);
      bus(1'b1, OFS_CTRL, 8'h80);
      for (int k = (s == 4) ? 0 : 2; k < 2; k++) u_ief_far_model.fire(s);
      rdchk(OFS_PREQ, 8'h00);
      u_ief_far_model.fire(s);
      rdchk(OFS_PREQ, masks[s-1]);
      irq_is(1'b0);
      bus(1'b1, OFS_CTRL, 8'hC0);
      irq_is(1'b1);
      bus(1'b1, OFS_PREQ, 8'h00);
      irq_is(1'b0);
    end
    // Pin-change summary
    bus(1'b1, OFS_CTRL, 8'h88);
    u_ief_far_model.set_pins(4'b1111);
    irq_is(1'b1);
    bus(1'b1, OFS_CTRL, 8'h88);
    rdchk(OFS_CTRL, 8'h89);
    u_ief_far_model.set_pins(4'b0110);
    rdchk(OFS_CTRL, 8'h89);
    u_ief_far_model.set_pins(4'b0000);
    rdchk(OFS_CTRL, 8'h88);
    irq_is(1'b0);
    // External pin edge select: falling first, then rising
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, OFS_CFG, 8'h20 | 8'(e));
      u_ief_far_model.set_ext(e == 1);
      repeat (6) @(posedge clk_i);
      bus(1'b1, OFS_CTRL, 8'h00);
      u_ief_far_model.set_ext(e == 0);
      repeat (6) @(posedge clk_i);
      rdchk(OFS_CTRL, 8'h00);
      u_ief_far_model.set_ext(e == 1);
      repeat (6) @(posedge clk_i);
      rdchk(OFS_CTRL, 8'h02);
    end
    // Reset in mid-run clears everything
    bus(1'b1, OFS_PEN, 8'h5A);
    bus(1'b1, OFS_PREQ, 8'h5A);
    bus(1'b1, OFS_CTRL, 8'hFE);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    irq_is(1'b0);
    for (int i = 0; i < 3; i++) begin
      rdchk(4'(4 * i), 8'h00);
    end
    print_verdict();
  end
endmodule
